// ### bench/sarseq_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
// analogue side: input sampled while tracking, compared against the dac code
module sarseq_cmp_model (
  input wire logic pclk,
  input wire logic input_track,
  input wire logic [11:0] capacitor_dac_code,
  input wire logic [11:0] vin,
  output logic cmp_below
);
  logic [11:0] held_q = 12'h000;
  always_ff @(posedge pclk) begin
    if (input_track) begin
      held_q <= vin;
    end
  end
  // equal is not above, so an exact code keeps its own trial bit
  assign cmp_below = (capacitor_dac_code <= held_q);
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_map.svh"
module testbench;
  localparam int CT = 280;
  localparam int TICK = CT * 100 / 1000 / 14;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic chip_act = 1'b1, sel_n = 1'b0, read_nconv = 1'b1, word_full = 1'b1, len_sel = 1'b0;
  logic [11:0] paddr = 12'h000, vin = 12'h000, data_out, data_oe, dac;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic pready, pslverr, busy, clk_en, track, eoc, cmp_below, err;
  int num_errors = 0, checks = 0, cyc = 0, seed = 59600, nb, nt, ne, busy12;

  initial begin
    forever #5 pclk = ~pclk;
  end

  sarseq_top #(.CONV_TIME_NS(CT)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_act(chip_act), .sel_n(sel_n), .read_nconv(read_nconv),
    .word_full(word_full), .byte_select_len(len_sel), .cmp_below(cmp_below),
    .conversion_busy_flag(busy), .conv_clk_en(clk_en), .input_track(track),
    .capacitor_dac_code(dac), .eoc(eoc), .data_out(data_out), .data_oe(data_oe)
  );

  sarseq_cmp_model i_cmp (
    .pclk(pclk), .input_track(track), .capacitor_dac_code(dac), .vin(vin),
    .cmp_below(cmp_below)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // request held until pready is seen high, data taken at that edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] expect_code(input logic [11:0] v, input logic l8);
    return l8 ? {v[11:4], 4'h8} : v;
  endfunction

  // w: 0..2 pin that arrives last, 3 software start
  task automatic conv(input int w, input logic l8, input logic [11:0] v);
    logic [11:0] e;
    e = expect_code(v, l8);
    @(posedge pclk);
    vin <= v;
    len_sel <= l8;
    if (w == 3) begin
      apb(`SARSEQ_ADDR_CTRL, 1'b1, 32'h1);
    end else begin
      chip_act <= (w != 1);
      sel_n <= (w == 2);
      read_nconv <= (w == 0);
      @(posedge pclk);
      chip_act <= 1'b1;
      sel_n <= 1'b0;
      read_nconv <= 1'b0;
      @(posedge pclk);
    end
    @(negedge pclk);
    if (w != 3) begin
      check(busy, 1'b1, "busy at start");
      check(clk_en, 1'b1, "clock on");
      check(dac, 12'h000, "sar cleared");
    end
    nb = 0;
    nt = 0;
    ne = 0;
    while (busy !== 1'b1 && nb < 20) begin
      @(negedge pclk);
      nb++;
    end
    check(busy, 1'b1, "busy seen");
    nb = 0;
    while (busy === 1'b1 && nb < 200) begin
      nb++;
      if (track === 1'b1) nt++;
      check(data_oe, 12'h000, "outputs off while busy");
      if (eoc === 1'b1) begin
        ne++;
        check(clk_en, 1'b0, "clock off at end");
      end
      @(posedge pclk);
      // restart attempt, new byte select and a new input after sampling
      if (nb == 3 * TICK) begin
        read_nconv <= 1'b1;
        vin <= ~v;
        len_sel <= ~l8;
      end
      if (nb == 3 * TICK + 2) read_nconv <= 1'b0;
      @(negedge pclk);
    end
    check(busy, 1'b0, "busy fell");
    check(ne, 1, "one end pulse");
    check(nt, 2 * TICK, "acquisition length");
    @(posedge pclk);
    read_nconv <= 1'b1;
    len_sel <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    check(data_oe, 12'hfff, "word enable");
    check(data_out, e, "result");
    for (int b = 0; b < 2; b++) begin
      @(posedge pclk);
      word_full <= 1'b0;
      len_sel <= b[0];
      @(posedge pclk);
      @(negedge pclk);
      check(data_oe, 12'hff0, "byte enable");
      check(data_out[11:4], b ? {e[3:0], 4'h0} : e[11:4], "byte data");
    end
    @(posedge pclk);
    word_full <= 1'b1;
    apb(`SARSEQ_ADDR_RESULT, 1'b0, 32'h0);
    check(rd, {20'h0, e}, "result register");
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(busy, 1'b0, "idle after reset");
    conv(0, 1'b0, 12'h000);
    busy12 = nb;
    check(busy12, 14 * TICK + 1, "conversion length");
    conv(0, 1'b0, 12'hfff);
    check(nb, busy12, "fixed length");
    conv(1, 1'b1, 12'hfff);
    check(busy12 - nb, 4 * TICK, "short conversion");
    conv(2, 1'b0, 12'h001);
    conv(3, 1'b0, 12'h800);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      conv(int'(r[1:0]), r[2] & (r[1:0] != 2'h3), r[15:4]);
    end
    apb(`SARSEQ_ADDR_CTRL, 1'b1, 32'h2);
    apb(`SARSEQ_ADDR_STATUS, 1'b0, 32'h0);
    check(rd[2:0], {1'b1, r[2] & (r[1:0] != 2'h3), 1'b0}, "status bipolar idle");
    apb(12'h0ff, 1'b0, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    end_sim();
  end
endmodule
`default_nettype wire

// ### core/sarseq_map.svh
`ifndef SARSEQ_MAP_SVH
`define SARSEQ_MAP_SVH

// apb register byte addresses
`define SARSEQ_ADDR_CTRL 12'h000
`define SARSEQ_ADDR_STATUS 12'h004
`define SARSEQ_ADDR_RESULT 12'h008

// ctrl fields
`define SARSEQ_CTRL_SWSTART 0
`define SARSEQ_CTRL_BIPOLAR 1

// status fields
`define SARSEQ_STAT_BUSY 0
`define SARSEQ_STAT_LEN8 1
`define SARSEQ_STAT_BIPOLAR 2

// conversion geometry
`define SARSEQ_NBITS 12
`define SARSEQ_ACQ_CYCLES 2'h2
`define SARSEQ_STEPS 14
`define SARSEQ_CODE_RESET 12'h000
`define SARSEQ_MSB_MASK 12'h800
`define SARSEQ_LSB12_MASK 12'h001
`define SARSEQ_LSB8_MASK 12'h010
`define SARSEQ_LEN8_TAIL 12'h008

// timing
`define SARSEQ_CONV_TIME_NS 8000
`define SARSEQ_CLK_MHZ 100

`endif

// ### core/sarseq_pkg.sv
package sarseq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_CONV,
    ST_DONE
  } sarseq_st_t;

  typedef struct packed {
    sarseq_st_t st;
    logic [15:0] div_cnt;
    logic [1:0] acq_cnt;
    logic [11:0] sar;
    logic [11:0] mask;
    logic len8;
    logic start_prev;
    logic busy;
    logic clk_en;
    logic track;
    logic eoc;
    logic [11:0] result;
    logic [11:0] data;
    logic [11:0] data_oe;
    logic bipolar;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sarseq_state_t;

endpackage

// ### core/sarseq_top.sv
// Contract
// R1: accepted start enables conversion clock and clears every sar bit.
// R2: a started conversion runs to completion; control inputs cannot stop it.
// R3: no conversion data on the outputs while converting.
// R4: end of conversion disables the conversion clock.
// R5: after clock stops, busy drops and result becomes readable.
// R6: bits trialled one at a time, msb first, lsb last.
// R7: keep bit if dac sum below input, else clear it.
// R8: after all bits the sar holds the full 12-bit result.
// R9: falling read-not-convert starts sampling and conversion timing.
// R10: first two clock ticks acquire the input onto the dac.
// R11: after the two acquisition ticks the sample is held, resolution begins.
// R12: analogue input stays disconnected from the dac after sampling.
// R13: bit period is a build parameter matching the conversion time grade.
// R14: no initialisation needed; converts on first start command.
// R15: unipolar result is straight binary, lowest input all zeros.
// R16: highest input decodes to all ones.
// R17: bipolar result is offset binary, negative full scale all zeros.
// R18: busy high only while converting; starts during busy are ignored.
// R19: start when chip active high, select low, read-not-convert low; last wins.
// R20: byte select latched at start: high gives 8 bits, low 12.
// R21: outputs enabled only for read, not busy, active, selected; width per word select.
// R22: end-of-conversion pulse in the cycle of the final lsb decision.
// R23: busy rises with the accepted start and stays high throughout.
`include "sarseq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int CONV_TIME_NS = `SARSEQ_CONV_TIME_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_act,
  input wire logic sel_n,
  input wire logic read_nconv,
  input wire logic word_full,
  input wire logic byte_select_len,
  input wire logic cmp_below,
  output logic conversion_busy_flag,
  output logic conv_clk_en,
  output logic input_track,
  output logic [11:0] capacitor_dac_code,
  output logic eoc,
  output logic [11:0] data_out,
  output logic [11:0] data_oe
);

  // whole 12-bit conversion = two acquisition ticks plus twelve bit ticks
  localparam int TICK_RAW = (CONV_TIME_NS * `SARSEQ_CLK_MHZ) / (1000 * `SARSEQ_STEPS);
  // a longest time rounds down, but never below one cycle
  localparam int TICK_CYC = (TICK_RAW < 1) ? 1 : TICK_RAW; // [R13]
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

  sarseq_state_t q;
  sarseq_state_t d;

  logic start_cond;
  logic start_rise;
  logic sw_start;
  logic tick;
  logic last;
  logic apb_done;
  logic [11:0] trial_sar;
  logic [11:0] trial_mask;

  // pin formatting: 12 bits at once, or left-justified byte pair on db11..db4
  function automatic logic [23:0] fmt_out(input logic [11:0] res, input logic full,
                                          input logic lo_byte);
    logic [11:0] dat;
    logic [11:0] oe;
    dat = res;
    oe = 12'hfff;
    if (!full) begin
      oe = 12'hff0;
      if (lo_byte) begin
        // trailing nibble forced low so the byte reads xxxx0000
        dat = {res[3:0], 4'h0, 4'h0};
      end else begin
        dat = {res[11:4], 4'h0};
      end
    end
    return {oe, dat};
  endfunction

  // last arrival among the three start terms makes the edge
  assign start_cond = chip_act && !sel_n && !read_nconv; // [R19] [R9]
  assign start_rise = start_cond && !q.start_prev; // [R19]
  assign apb_done = psel && penable && q.pready;
  assign sw_start = apb_done && pwrite && (paddr == `SARSEQ_ADDR_CTRL) &&
                    pwdata[`SARSEQ_CTRL_SWSTART];
  assign tick = q.clk_en && (q.div_cnt == TICK_LAST); // [R13]
  assign last = q.len8 ? (q.mask == `SARSEQ_LSB8_MASK)
                       : (q.mask == `SARSEQ_LSB12_MASK); // [R20]

  sarseq_trial u_trial (
    .sar(q.sar),
    .mask(q.mask),
    .cmp_below(cmp_below),
    .last(last),
    .sar_next(trial_sar),
    .mask_next(trial_mask)
  );

  always_comb begin
    d = q;
    d.start_prev = start_cond;
    d.eoc = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // divider runs only while the conversion clock is gated on
    if (q.clk_en) begin
      d.div_cnt = tick ? 16'h0000 : (q.div_cnt + 16'h0001);
    end
    case (q.st)
      ST_IDLE: begin
        // nothing to set up after power-up: first start converts
        if (start_rise || sw_start) begin // [R14] [R9]
          d.st = ST_ACQ;
          d.busy = 1'b1; // [R23]
          d.clk_en = 1'b1; // [R1]
          d.sar = `SARSEQ_CODE_RESET; // [R1]
          d.mask = `SARSEQ_CODE_RESET;
          d.len8 = byte_select_len; // [R20]
          d.track = 1'b1; // [R10]
          d.acq_cnt = 2'h0;
          d.div_cnt = 16'h0000;
        end
      end
      ST_ACQ: begin
        if (tick) begin
          if (q.acq_cnt == (`SARSEQ_ACQ_CYCLES - 2'h1)) begin // [R10]
            d.st = ST_CONV;
            d.track = 1'b0; // [R11] [R12]
            d.mask = `SARSEQ_MSB_MASK; // [R6]
            d.sar = `SARSEQ_MSB_MASK;
          end else begin
            d.acq_cnt = q.acq_cnt + 2'h1;
          end
        end
      end
      ST_CONV: begin
        // start pins are not looked at here: the cycle cannot be restarted
        if (tick) begin // [R2]
          d.sar = trial_sar; // [R7]
          d.mask = trial_mask; // [R6]
          if (last) begin
            d.eoc = 1'b1; // [R22]
            d.clk_en = 1'b0; // [R4]
            d.st = ST_DONE;
            if (q.len8) begin
              // short cycle leaves the next trial bit set, lower bits zero
              d.sar = trial_sar | `SARSEQ_LEN8_TAIL; // [R20]
            end
          end
        end
      end
      ST_DONE: begin
        // clock already off; busy falls one cycle later
        d.busy = 1'b0; // [R5] [R18]
        // same bits serve straight and offset binary; coding is set by the range
        d.result = q.sar; // [R8] [R15] [R16] [R17]
        d.st = ST_IDLE;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // register writes complete on the edge that sees pready
    if (apb_done && pwrite && (paddr == `SARSEQ_ADDR_CTRL)) begin
      d.bipolar = pwdata[`SARSEQ_CTRL_BIPOLAR];
    end
    // one wait state: pready comes on the second access cycle
    if (psel && penable && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      if (paddr == `SARSEQ_ADDR_CTRL) begin
        d.prdata[`SARSEQ_CTRL_BIPOLAR] = q.bipolar;
      end else if (paddr == `SARSEQ_ADDR_STATUS) begin
        d.prdata[`SARSEQ_STAT_BUSY] = q.busy;
        d.prdata[`SARSEQ_STAT_LEN8] = q.len8;
        d.prdata[`SARSEQ_STAT_BIPOLAR] = q.bipolar;
      end else if (paddr == `SARSEQ_ADDR_RESULT) begin
        // result is hidden while busy, as on the pins
        d.prdata[11:0] = q.busy ? 12'h000 : q.result; // [R3]
      end else begin
        d.pslverr = 1'b1;
      end
    end
    // enables use next busy so no data leaks in the start cycle
    {d.data_oe, d.data} = 24'h00_0000;
    if (read_nconv && !d.busy && chip_act && !sel_n) begin // [R21] [R3] [R5]
      {d.data_oe, d.data} = fmt_out(d.result, word_full, byte_select_len); // [R21]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign conversion_busy_flag = q.busy;
  assign conv_clk_en = q.clk_en;
  assign input_track = q.track;
  assign capacitor_dac_code = q.sar;
  assign eoc = q.eoc;
  assign data_out = q.data;
  assign data_oe = q.data_oe;

  logic accept;
  assign accept = (q.st == ST_IDLE) && (start_rise || sw_start);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_start_clears;
    accept |=> (q.sar == 12'h000) && q.clk_en && q.busy && q.track;
  endproperty
  a_start_clears: assert property (p_start_clears) // [R1] [R23]
    else $error("start did not clear sar or enable clock");

  property p_no_restart;
    (q.st == ST_CONV) |=> (q.st == ST_CONV) || (q.st == ST_DONE);
  endproperty
  a_no_restart: assert property (p_no_restart) // [R2]
    else $error("conversion left early");

  property p_hidden_busy;
    q.busy |-> (q.data_oe == 12'h000) && (q.data == 12'h000);
  endproperty
  a_hidden_busy: assert property (p_hidden_busy) // [R3]
    else $error("data enabled while busy");

  property p_eoc_clock_off;
    q.eoc |-> !q.clk_en && q.busy ##1 !q.busy && !q.clk_en;
  endproperty
  a_eoc_clock_off: assert property (p_eoc_clock_off) // [R4] [R5]
    else $error("clock or busy wrong around end of conversion");

  property p_mask_walk;
    (q.st == ST_CONV) && tick && !last |=> q.mask == ($past(q.mask) >> 1);
  endproperty
  a_mask_walk: assert property (p_mask_walk) // [R6]
    else $error("trial bit did not step down by one");

  property p_bit_clear;
    (q.st == ST_CONV) && tick && !cmp_below |=> (q.sar & $past(q.mask)) == 12'h000;
  endproperty
  a_bit_clear: assert property (p_bit_clear) // [R7]
    else $error("bit kept although sum above input");

  property p_acq_two;
    $fell(q.track) |-> (q.st == ST_CONV) && ($past(q.acq_cnt) == 2'h1) &&
                       (q.mask == 12'h800);
  endproperty
  a_acq_two: assert property (p_acq_two) // [R10] [R11]
    else $error("hold taken without two acquisition ticks");

  property p_isolated;
    (q.st == ST_CONV) || (q.st == ST_DONE) |-> !q.track;
  endproperty
  a_isolated: assert property (p_isolated) // [R12]
    else $error("input connected after sampling");

  property p_ignore_start;
    q.busy && (q.st != ST_DONE) && start_rise |=> q.busy && $stable(q.len8);
  endproperty
  a_ignore_start: assert property (p_ignore_start) // [R18]
    else $error("start during busy disturbed conversion");

  property p_short_tail;
    q.eoc && q.len8 |-> (q.sar[3:0] == 4'h8);
  endproperty
  a_short_tail: assert property (p_short_tail) // [R20]
    else $error("8-bit result tail wrong");

  property p_len_latch;
    accept |=> q.len8 == $past(byte_select_len);
  endproperty
  a_len_latch: assert property (p_len_latch) // [R20]
    else $error("conversion length not taken at start");

  property p_eoc_on_tick;
    q.eoc |-> $past(tick) && ($past(q.st) == ST_CONV);
  endproperty
  a_eoc_on_tick: assert property (p_eoc_on_tick) // [R22]
    else $error("end pulse not on a bit tick");

endmodule

`default_nettype wire

// ### core/sarseq_trial.sv
`timescale 1ns/1ps
`default_nettype none

// one successive-approximation decision plus the next trial bit
module sarseq_trial (
  input wire logic [11:0] sar,
  input wire logic [11:0] mask,
  input wire logic cmp_below,
  input wire logic last,
  output logic [11:0] sar_next,
  output logic [11:0] mask_next
);

  always_comb begin
    // keep the trial bit only while the dac sum stays below the input
    sar_next = cmp_below ? sar : (sar & ~mask); // [R7]
    mask_next = mask >> 1; // [R6]
    if (!last) begin
      sar_next = sar_next | mask_next; // [R6]
    end
  end

endmodule

`default_nettype wire
